// ===== rtl/program_memory_table_read.v
// Read side of the flash program store: fetch and table reads for the core.
// Assumes the core holds requests steady and the programmer supplies words
// already deserialised by logic outside this block.
//
// Function
// - Store holds 1K or 2K 14-bit words.
// - Fetch starts at word zero after reset; the block fetches from i_program_counter, RESET_VECTOR is unused.
// - Table pointer selects the table word.
// - Low byte goes to operand register.
// - Upper bits load the table high byte.
// - Unused high byte bits read zero.
// - Current page variant offsets from current page.
// - Last page variant offsets from last page.
// - Table high byte ignores software writes.
// - Table reads take two instruction cycles.
// - Programming uses serial data and clock lines.
// - Debug data pin two-way, clock input.
// - Debug mode disables shared pin functions.
// - Debug pins still serve as programming pins.
// - A page spans 256 words.
`timescale 1ns/1ps
`default_nettype none
`include "program_memory_table_read_regs.vh"

module program_memory_table_read #(
  parameter ADDR_WIDTH = 10
) (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // Instruction fetch
  input wire i_fetch,
  input wire [ADDR_WIDTH-1:0] i_program_counter,
  output reg [`WORD_WIDTH-1:0] o_instruction,
  output reg o_instruction_valid,
  output wire o_busy,
  // Table read request
  input wire i_table_read,
  input wire i_table_read_current_page,
  input wire [7:0] i_table_pointer,
  input wire [7:0] i_operand_addr,
  input wire i_table_high_write,
  // Table read result
  output reg o_data_write,
  output reg [7:0] o_data_addr,
  output reg [7:0] o_data_value,
  output reg [7:0] o_table_high_byte,
  // Programming word path
  input wire i_prog_write,
  input wire [ADDR_WIDTH-1:0] i_prog_addr,
  input wire [`WORD_WIDTH-1:0] i_prog_data,
  // Shared programming and debug pins
  input wire i_debug_mode,
  input wire i_prog_serial_data,
  input wire i_prog_serial_clock,
  input wire i_prog_data_out,
  input wire i_prog_data_drive,
  input wire i_func_data_out,
  input wire i_func_data_oe_n,
  output wire o_prog_serial_data,
  output wire o_prog_serial_data_oe_n,
  output wire o_serial_data_in,
  output wire o_serial_clock_in,
  output wire o_func_pin_data_in,
  output wire o_func_pin_clock_in
);

  // ----------------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------------

  localparam ST_IDLE = 2'h0;
  localparam ST_TABLE = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam HIGH_WIDTH = `TABLE_HIGH_MSB - `TABLE_HIGH_LSB + 1;
  localparam PIN_COUNT = 2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] cycle_reg;
  reg [1:0] cycle_next;
  reg [7:0] operand_reg;
  reg fetch_reg;
  reg [ADDR_WIDTH-1:0] read_addr;
  wire [`WORD_WIDTH-1:0] word;
  wire table_take;
  wire fetch_take;
  wire table_load;
  wire [7:0] high_byte_next;
  wire [PIN_COUNT-1:0] pin_level;
  wire [PIN_COUNT-1:0] func_level;
  genvar bit_index;
  genvar pin_index;

  // ----------------------------------------------------------------------
  // Request decoding
  // ----------------------------------------------------------------------

  // A request is only taken while idle, so a busy cycle refuses both kinds.
  function takes_table;
    input [1:0] state;
    input table_read;
    begin
      takes_table = (state == ST_IDLE) && table_read;
    end
  endfunction

  function takes_fetch;
    input [1:0] state;
    input fetch;
    input table_read;
    begin
      takes_fetch = (state == ST_IDLE) && fetch && !table_read;
    end
  endfunction

  assign table_take = takes_table(state_reg, i_table_read);
  assign fetch_take = takes_fetch(state_reg, i_fetch, i_table_read);
  assign table_load = (state_reg == ST_TABLE);

  // The page bits come from the program counter or are forced to all ones.
  function [ADDR_WIDTH-1:0] table_addr;
    input current_page;
    input [ADDR_WIDTH-1:0] pc;
    input [7:0] pointer;
    begin
      if (current_page) begin
        table_addr = {pc[ADDR_WIDTH-1:`PAGE_BITS], pointer};
      end else begin
        table_addr = {{(ADDR_WIDTH-`PAGE_BITS){1'b1}}, pointer};
      end
    end
  endfunction

  always @* begin
    if (table_take) begin
      read_addr = table_addr(i_table_read_current_page, i_program_counter,
        i_table_pointer);
    end else begin
      read_addr = i_program_counter;
    end
  end

  program_word_store #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .DATA_WIDTH(`WORD_WIDTH)
  ) store (
    .i_clock(i_clock),
    .i_read_addr(read_addr),
    .o_read_data(word),
    .i_write(i_prog_write),
    .i_write_addr(i_prog_addr),
    .i_write_data(i_prog_data)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------

  // Holding the core for a second cycle keeps fetch off the store port.
  assign o_busy = (state_reg != ST_IDLE);

  always @* begin
    state_next = state_reg;
    cycle_next = cycle_reg;
    case (state_reg)
      ST_IDLE: begin
        cycle_next = 2'h0;
        if (table_take) begin
          state_next = ST_TABLE;
          cycle_next = 2'h1;
        end
      end
      ST_TABLE: begin
        state_next = ST_DONE;
        cycle_next = cycle_reg + 2'h1;
      end
      ST_DONE: begin
        // The count ends the read after its second instruction cycle.
        if (cycle_reg == `TABLE_READ_CYCLES) begin
          state_next = ST_IDLE;
          cycle_next = 2'h0;
        end else begin
          cycle_next = cycle_reg + 2'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cycle_next = 2'h0;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      cycle_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cycle_reg <= cycle_next;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction fetch
  // ----------------------------------------------------------------------

  // The store answers one clock after its address, so the take is held for a
  // cycle and the word is captured as it leaves the store.
  always @(posedge i_clock) begin
    if (i_reset) begin
      fetch_reg <= 1'b0;
      o_instruction <= {`WORD_WIDTH{1'b0}};
      o_instruction_valid <= 1'b0;
    end else begin
      fetch_reg <= fetch_take;
      o_instruction_valid <= fetch_reg;
      if (fetch_reg) begin
        o_instruction <= word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Table read result
  // ----------------------------------------------------------------------

  // The operand is kept from the take, since the core may move on to other
  // work while the word is still on its way out of the store.
  always @(posedge i_clock) begin
    if (i_reset) begin
      operand_reg <= 8'h00;
      o_data_write <= 1'b0;
      o_data_addr <= 8'h00;
      o_data_value <= 8'h00;
    end else begin
      o_data_write <= table_load;
      if (table_take) begin
        operand_reg <= i_operand_addr;
      end
      if (table_load) begin
        o_data_addr <= operand_reg;
        o_data_value <= word[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Table high byte
  // ----------------------------------------------------------------------

  // Only the word bits above the low byte exist; the rest is tied low.
  generate
    for (bit_index = 0; bit_index < 8; bit_index = bit_index + 1) begin : high_bits
      if (bit_index < HIGH_WIDTH) begin : used
        assign high_byte_next[bit_index] = word[`TABLE_HIGH_LSB + bit_index];
      end else begin : unused
        assign high_byte_next[bit_index] = 1'b0;
      end
    end
  endgenerate

  // Software cannot restore this register, so a write attempt is dropped. The
  // hardware load comes last so that it wins when both fall in one cycle.
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_table_high_byte <= `TABLE_HIGH_RESET;
    end else begin
      if (i_table_high_write) begin
        o_table_high_byte <= o_table_high_byte;
      end
      if (table_load) begin
        o_table_high_byte <= high_byte_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shared pins
  // ----------------------------------------------------------------------

  // The serial programming protocol is decoded outside this block; only the
  // ownership of the two shared pins is settled here.
  assign pin_level = {i_prog_serial_clock, i_prog_serial_data};

  generate
    for (pin_index = 0; pin_index < PIN_COUNT; pin_index = pin_index + 1) begin : func_gate
      // In debug use the normal function sees a quiet low level instead.
      assign func_level[pin_index] = i_debug_mode ? 1'b0 : pin_level[pin_index];
    end
  endgenerate

  // Programming owns the data pin whenever it drives, debug mode or not.
  assign o_prog_serial_data = i_prog_data_drive ? i_prog_data_out : i_func_data_out;
  assign o_prog_serial_data_oe_n = i_prog_data_drive ? 1'b0 :
    (i_debug_mode ? 1'b1 : i_func_data_oe_n);
  assign o_serial_data_in = pin_level[0];
  assign o_serial_clock_in = pin_level[1];
  assign o_func_pin_data_in = func_level[0];
  assign o_func_pin_clock_in = func_level[1];

endmodule

`default_nettype wire

// ===== rtl/program_memory_table_read_regs.vh
// Constants for the program memory table read block.
// Assumes inclusion by the table read design files and the testbench only.
`ifndef PROGRAM_MEMORY_TABLE_READ_REGS_VH
`define PROGRAM_MEMORY_TABLE_READ_REGS_VH

`define WORD_WIDTH 14
`define PAGE_BITS 8
`define RESET_VECTOR 11'h000
`define TABLE_HIGH_RESET 8'h00
`define TABLE_HIGH_LSB 8
`define TABLE_HIGH_MSB 13
`define TABLE_READ_CYCLES 2'h2
`define LAST_PAGE_1K 10'h300

`endif

// ===== rtl/program_word_store.v
// Program word store: one read port, one write port for the programming path.
// Assumes a single clock; reads return data one clock after the address.
`timescale 1ns/1ps
`default_nettype none

module program_word_store #(
  parameter ADDR_WIDTH = 10,
  parameter DATA_WIDTH = 14
) (
  // Clock
  input wire i_clock,
  // Read port
  input wire [ADDR_WIDTH-1:0] i_read_addr,
  output reg [DATA_WIDTH-1:0] o_read_data,
  // Write port
  input wire i_write,
  input wire [ADDR_WIDTH-1:0] i_write_addr,
  input wire [DATA_WIDTH-1:0] i_write_data
);

  reg [DATA_WIDTH-1:0] words [0:(1<<ADDR_WIDTH)-1];

  always @(posedge i_clock) begin
    if (i_write) begin
      words[i_write_addr] <= i_write_data;
    end
    o_read_data <= words[i_read_addr];
  end

endmodule

`default_nettype wire

// ===== tb/table_read_properties.sv
// Port timing checks for the table read block.
// Assumes a bind onto the top module, one clock.
`timescale 1ns/1ps
`default_nettype none
module table_read_properties (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_fetch,
  input wire logic i_table_read,
  input wire logic o_busy,
  input wire logic o_data_write,
  input wire logic o_instruction_valid,
  input wire logic [7:0] o_table_high_byte
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire logic take = i_table_read && !o_busy;
  wire logic pull = i_fetch && !i_table_read && !o_busy;
  chk_busy_span: assert property (take |=> o_busy [*2] ##1 !o_busy)
    else $error("busy span");
  chk_write_time: assert property (take |=> !o_data_write ##1 o_data_write)
    else $error("write time");
  chk_write_cause: assert property (o_data_write |-> $past(take, 2))
    else $error("write cause");
  chk_write_lone: assert property (o_data_write |=> !o_data_write)
    else $error("write pulse");
  chk_high_pad: assert property (o_table_high_byte[7:6] == 2'h0)
    else $error("high pad");
  chk_high_hold: assert property (!o_data_write |-> $stable(o_table_high_byte))
    else $error("high hold");
  chk_fetch_answer: assert property (pull |-> ##2 o_instruction_valid)
    else $error("fetch answer");
  chk_valid_cause: assert property (o_instruction_valid |-> $past(pull, 2))
    else $error("valid cause");
  cover property (take ##2 o_data_write);
  cover property (pull ##2 o_instruction_valid);
  cover property (o_busy && i_table_read);
endmodule
bind program_memory_table_read table_read_properties chk (.i_clock, .i_reset, .i_fetch,
  .i_table_read, .o_busy, .o_data_write, .o_instruction_valid, .o_table_high_byte);
`default_nettype wire

// ===== tb/data_memory_model.sv
// Core register file that takes table read low bytes.
// Assumes one-cycle write pulses on the block clock.
`timescale 1ns/1ps
`default_nettype none
module data_memory_model (
  input wire logic i_clock,
  input wire logic i_write,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_value,
  input wire logic [7:0] i_look,
  output logic [7:0] o_look
);
  logic [7:0] mem [0:255];
  always @(posedge i_clock) begin
    if (i_write) begin
      mem[i_addr] <= i_value;
    end
  end
  assign o_look = mem[i_look];
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the table read block, 1K-word build.
// Assumes the data memory model stands as the core.
`timescale 1ns/1ps
`default_nettype none
`include "program_memory_table_read_regs.vh"
module testbench;
  logic i_clock = 0, i_reset = 1, i_fetch = 0, i_table_read = 0, i_table_read_current_page = 0;
  logic i_table_high_write = 0, i_prog_write = 0, i_debug_mode = 0, i_prog_serial_data = 0;
  logic i_prog_serial_clock = 0, i_prog_data_out = 0, i_prog_data_drive = 0;
  logic i_func_data_out = 0, i_func_data_oe_n = 1, o_instruction_valid, o_busy, o_data_write;
  logic o_prog_serial_data, o_prog_serial_data_oe_n, o_serial_data_in, o_serial_clock_in;
  logic o_func_pin_data_in, o_func_pin_clock_in;
  logic [9:0] i_program_counter = 0, i_prog_addr = 0;
  logic [13:0] o_instruction, i_prog_data = 0;
  logic [7:0] i_table_pointer = 0, i_operand_addr = 0, o_data_addr, o_data_value, look = 0, seen;
  logic [7:0] o_table_high_byte;
  wire [3:0] pin_view = {o_func_pin_data_in, o_func_pin_clock_in, o_prog_serial_data,
    o_prog_serial_data_oe_n};
  int fail_count = 0, tests_run = 0, cycles = 0;
  program_memory_table_read #(.ADDR_WIDTH(10)) dut (.*);
  data_memory_model core (.i_clock, .i_write(o_data_write), .i_addr(o_data_addr),
    .i_value(o_data_value), .i_look(look), .o_look(seen));
  always #5 i_clock = ~i_clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic put(input logic [9:0] a, input logic [13:0] d);
    @(negedge i_clock);
    i_prog_write = 1;
    i_prog_addr = a;
    i_prog_data = d;
    @(negedge i_clock);
    i_prog_write = 0;
  endtask
  task automatic fetch_zero();
    @(negedge i_clock);
    i_fetch = 1;
    @(negedge i_clock);
    i_fetch = 0;
    @(posedge i_clock);
    #1 chk({o_instruction_valid, 1'b0, o_instruction}, 16'h8abc);
    @(posedge i_clock);
    #1 chk({15'h0000, o_instruction_valid}, 16'h0000);
  endtask
  // A second request while busy must be ignored, so hold may keep it up.
  task automatic tread(input logic cur, hold, input logic [7:0] ptr, op, input logic [15:0] exp);
    @(negedge i_clock);
    i_table_high_write = 0;
    i_program_counter = 10'h1f0;
    i_table_read = 1;
    i_table_read_current_page = cur;
    i_table_pointer = ptr;
    i_operand_addr = op;
    @(negedge i_clock);
    i_table_read = hold;
    i_table_high_write = 1;
    @(posedge i_clock);
    #1 chk({o_data_write, o_table_high_byte[6:0], o_data_value}, exp);
    chk({8'h00, o_data_addr}, {8'h00, op});
    chk({14'h0000, o_busy, o_data_write}, 16'h0003);
    @(negedge i_clock);
    i_table_read = 0;
    @(posedge i_clock);
    #1 chk({6'h00, o_busy, o_data_write, o_table_high_byte}, {9'h000, exp[14:8]});
  endtask
  task automatic pins();
    @(negedge i_clock);
    i_prog_serial_data = 1;
    i_prog_serial_clock = 1;
    i_func_data_out = 1;
    i_func_data_oe_n = 0;
    #1 chk({12'h000, pin_view}, 16'h000e);
    @(negedge i_clock);
    i_debug_mode = 1;
    #1 chk({12'h000, pin_view}, 16'h0003);
    chk({14'h0000, o_serial_data_in, o_serial_clock_in}, 16'h0003);
    @(negedge i_clock);
    i_prog_data_drive = 1;
    #1 chk({12'h000, pin_view}, 16'h0000);
  endtask
  initial begin
    repeat (5) @(negedge i_clock);
    i_reset = 0;
    put(10'h000, 14'h0abc);
    put(`LAST_PAGE_1K + 10'h006, 14'h2a1a);
    put(`LAST_PAGE_1K + 10'h005, 14'h000f);
    put(10'h106, 14'h3f55);
    put(10'h1ff, 14'h1677);
    fetch_zero();
    tread(1, 0, 8'h06, 8'h46, 16'hbf55);
    tread(0, 0, 8'h06, 8'h46, 16'haa1a);
    tread(0, 1, 8'h05, 8'h47, 16'h800f);
    tread(1, 0, 8'hff, 8'h48, 16'h9677);
    pins();
    look = 8'h46;
    #1 chk({8'h00, seen}, 16'h001a);
    wrap_up();
  end
endmodule
`default_nettype wire
